// File: shared/sld_map.svh
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// word width of the shift chain and of the output register
`define SLD_WIDTH 16
// buffer depth between capture and output register
`define SLD_BUF_DEPTH 2

// driver level for an output that is off
`define SLD_OUT_OFF 16'h0000
// reset value of shift chain, pending word and output register
`define SLD_WORD_RST 16'h0000
// cascade output level while cleared
`define SLD_CAS_OFF 1'b0

// bit positions of the synchronised control pins
`define SLD_PIN_LAT 0
`define SLD_PIN_DIS 1
`define SLD_PIN_CLR 2

// synchroniser reset values: latch holding, outputs off, cleared
`define SLD_PINS_RST 3'h2
`define SLD_TOG_RST 3'h0

// shortest shift clock period, and the same in core cycles
`define SLD_SCK_MIN_NS 100
`define SLD_CLK_NS 10
`define SLD_SCK_MIN_CYC (`SLD_SCK_MIN_NS / `SLD_CLK_NS)

`endif

// File: shared/sld_pkg.sv
package sld_pkg;
    `include "sld_map.svh"

    typedef logic [`SLD_WIDTH-1:0] sld_word_t;

    // capture stage states
    typedef enum logic [1:0] {
        SLD_CAP_IDLE = 2'h1,
        SLD_CAP_PEND = 2'h2
    } sld_cap_e;

    // link-domain state
    typedef struct packed {
        sld_word_t stage;
        logic tog;
    } sld_shift_s;

    // buffer state
    typedef struct packed {
        logic [`SLD_BUF_DEPTH-1:0][`SLD_WIDTH-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } sld_buf_s;

    // core-domain state of the top
    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [2:0] tog_s;
        sld_cap_e cap;
        sld_word_t pend;
        sld_word_t hold;
        sld_word_t drv;
    } sld_top_s;
endpackage

// File: logic/sld_shift.sv
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_shift
    import sld_pkg::*;
(
    input wire logic i_shift_clk,
    input wire logic i_clear_n,
    input wire logic i_serial_data_in,
    output logic [`SLD_WIDTH-1:0] o_stage,
    output logic o_tog,
    output logic o_cascade_out
);

    sld_shift_s st_reg;
    sld_shift_s st_next;
    logic cascade_reg;

    // advance chain, newest bit into stage one, flag each shift
    always_comb
    begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[`SLD_WIDTH-2:0],
                         i_serial_data_in};
        st_next.tog = ~st_reg.tog;
    end

    // clear acts at once and blocks every shift edge
    always_ff @(posedge i_shift_clk or negedge i_clear_n)
    begin
        if (!i_clear_n)
        begin
            st_reg <= '{stage: `SLD_WORD_RST, tog: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // last stage leaves on the falling edge for the next device
    always_ff @(negedge i_shift_clk or negedge i_clear_n)
    begin
        if (!i_clear_n)
        begin
            cascade_reg <= `SLD_CAS_OFF;
        end
        else
        begin
            cascade_reg <= st_reg.stage[`SLD_WIDTH-1];
        end
    end

    assign o_stage = st_reg.stage;
    assign o_tog = st_reg.tog;
    assign o_cascade_out = cascade_reg;

    // chain moves by one place per edge; attempts span two live edges
    // so an edge ignored under clear is never taken as history
    shift_advance_a: assert property (
        @(posedge i_shift_clk) disable iff (!i_clear_n)
        1'b1 |=> st_reg.stage[`SLD_WIDTH-1:1] ==
            $past(st_reg.stage[`SLD_WIDTH-2:0]))
        else $error("shift chain did not advance");

    // serial bit lands in stage one
    first_stage_a: assert property (
        @(posedge i_shift_clk) disable iff (!i_clear_n)
        1'b1 |=> st_reg.stage[0] == $past(i_serial_data_in))
        else $error("serial bit not captured");

    // cascade shows last stage before the next rising edge
    cascade_out_a: assert property (
        @(posedge i_shift_clk) disable iff (!i_clear_n)
        o_cascade_out == st_reg.stage[`SLD_WIDTH-1])
        else $error("cascade output not last stage");

endmodule // sld_shift

// File: logic/sld_buf.sv
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_buf
    import sld_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [`SLD_WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [`SLD_WIDTH-1:0] o_out_data
);

    sld_buf_s st_reg;
    sld_buf_s st_next;
    logic push;
    logic pop;

    // handshakes on both sides
    assign o_in_ready = (st_reg.cnt != 2'h2);
    assign o_out_valid = (st_reg.cnt != 2'h0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = st_reg.mem[st_reg.rd];

    // write entry, move pointers, track fill
    always_comb
    begin
        st_next = st_reg;
        for (int i = 0; i < `SLD_BUF_DEPTH; i++)
        begin
            if (push && (st_reg.wr == 1'(i)))
            begin
                st_next.mem[i] = i_in_data;
            end
        end
        if (push)
        begin
            st_next.wr = ~st_reg.wr;
        end
        if (pop)
        begin
            st_next.rd = ~st_reg.rd;
        end
        case ({push, pop})
            2'b10: st_next.cnt = st_reg.cnt + 2'h1;
            2'b01: st_next.cnt = st_reg.cnt - 2'h1;
            default: st_next.cnt = st_reg.cnt;
        endcase
        if (i_flush)
        begin
            st_next.wr = 1'b0;
            st_next.rd = 1'b0;
            st_next.cnt = 2'h0;
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // a lone push raises the fill by one
    push_fill_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (push && !pop && !i_flush) |=> st_reg.cnt == $past(st_reg.cnt) + 2'h1)
        else $error("buffer fill wrong after push");

    // first word in is the first word out
    fifo_order_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.cnt == 2'h0 && push && !i_flush) |=>
            (o_out_valid && o_out_data == $past(i_in_data)))
        else $error("buffer order broken");

endmodule // sld_buf

// File: logic/sld_top.sv
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_top
    import sld_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_shift_clk,
    input wire logic i_serial_data_in,
    input wire logic i_clear_n,
    input wire logic i_latch,
    input wire logic i_output_disable,
    output logic [`SLD_WIDTH-1:0] o_driver_outputs,
    output logic o_cascade_out
);

    sld_top_s st_reg;
    sld_top_s st_next;

    // link-domain outputs
    sld_word_t link_word;
    logic link_tog;

    // buffer handshake
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    sld_word_t buf_out_data;
    logic buf_flush;

    // synchronised controls
    logic lat_s;
    logic dis_s;
    logic clr_s;
    logic tog_edge;

    // shift chain on the link clock, cleared straight from the pin
    sld_shift u_shift
    (
        .i_shift_clk(i_shift_clk),
        .i_clear_n(i_clear_n),
        .i_serial_data_in(i_serial_data_in),
        .o_stage(link_word),
        .o_tog(link_tog),
        .o_cascade_out(o_cascade_out)
    );

    // two-entry buffer between capture and output register
    sld_buf u_buf
    (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_flush(buf_flush),
        .i_in_valid(buf_in_valid),
        .o_in_ready(buf_in_ready),
        .i_in_data(st_reg.pend),
        .o_out_valid(buf_out_valid),
        .i_out_ready(buf_out_ready),
        .o_out_data(buf_out_data)
    );

    // off level wins whenever disabled or cleared
    function automatic sld_word_t drive_word(input sld_word_t w,
                                             input logic off);
        drive_word = off ? `SLD_OUT_OFF : w;
    endfunction

    // second synchroniser stage only; first stage feeds nothing else
    assign lat_s = st_reg.pin_s2[`SLD_PIN_LAT];
    assign dis_s = st_reg.pin_s2[`SLD_PIN_DIS];
    assign clr_s = st_reg.pin_s2[`SLD_PIN_CLR];

    // one change of the shift flag per shift edge
    assign tog_edge = st_reg.tog_s[1] ^ st_reg.tog_s[2];

    // pending word offered while the capture stage holds one and clear is released
    assign buf_in_valid = (st_reg.cap == SLD_CAP_PEND) && clr_s;
    assign buf_flush = !clr_s;

    // transparent latch drains the buffer, holding latch stalls it
    assign buf_out_ready = lat_s && clr_s;

    // next state of the core domain
    always_comb
    begin
        st_next = st_reg;

        // pins and shift flag pass two flops before use
        st_next.pin_s1 = {i_clear_n, i_output_disable, i_latch};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.tog_s = {st_reg.tog_s[1:0], link_tog};

        // capture the chain once it has settled after a shift
        case (st_reg.cap)
            SLD_CAP_IDLE:
            begin
                if (tog_edge)
                begin
                    st_next.pend = link_word;
                    st_next.cap = SLD_CAP_PEND;
                end
            end
            SLD_CAP_PEND:
            begin
                if (tog_edge)
                begin
                    // a newer word replaces the pending one, whether or not the buffer took it
                    st_next.pend = link_word;
                end
                else if (buf_in_ready)
                begin
                    st_next.cap = SLD_CAP_IDLE;
                end
            end
            default:
            begin
                st_next.cap = SLD_CAP_IDLE;
            end
        endcase

        // output register takes the oldest buffered word
        if (buf_out_valid && buf_out_ready)
        begin
            st_next.hold = buf_out_data;
        end

        // clear empties the capture path and the output register
        if (!clr_s)
        begin
            st_next.cap = SLD_CAP_IDLE;
            st_next.pend = `SLD_WORD_RST;
            st_next.hold = `SLD_WORD_RST;
        end

        // drivers follow the register unless disabled or cleared
        st_next.drv = drive_word(st_reg.hold,
                                 dis_s || !clr_s);
    end

    // core state register
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= '{pin_s1: `SLD_PINS_RST,
                        pin_s2: `SLD_PINS_RST,
                        tog_s: `SLD_TOG_RST,
                        cap: SLD_CAP_IDLE,
                        pend: `SLD_WORD_RST,
                        hold: `SLD_WORD_RST,
                        drv: `SLD_OUT_OFF};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // driver pins come straight from the register
    assign o_driver_outputs = st_reg.drv;

    // disable turns every driver off one cycle later
    dis_off_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        dis_s |=> o_driver_outputs == `SLD_OUT_OFF)
        else $error("drivers on while disabled");

    // clear turns drivers off and empties the output register
    clr_off_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !clr_s |=> (o_driver_outputs == `SLD_OUT_OFF &&
                    st_reg.hold == `SLD_WORD_RST))
        else $error("clear did not turn outputs off");

    // enabled drivers show the output register
    drv_follow_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!dis_s && clr_s) |=> o_driver_outputs == $past(st_reg.hold))
        else $error("drivers differ from output register");

    // holding latch keeps the register still
    latch_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!lat_s && clr_s) |=> $stable(st_reg.hold))
        else $error("output register moved while holding");

    // transparent latch takes the buffered word
    latch_follow_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (lat_s && clr_s && buf_out_valid) |=>
            st_reg.hold == $past(buf_out_data))
        else $error("output register missed a word");

    // a buffered word reaches the pins two cycles on
    word_to_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (lat_s && clr_s && !dis_s && buf_out_valid) ##1
            (clr_s && !dis_s) |=>
            o_driver_outputs == $past(buf_out_data, 2))
        else $error("word did not reach driver pins");

    // each shift is captured from the settled chain
    shift_capture_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (tog_edge && clr_s) |=>
            (st_reg.cap == SLD_CAP_PEND && st_reg.pend == $past(link_word)))
        else $error("shifted word not captured");

    // a refused word is kept until a newer shift replaces it
    no_drop_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.cap == SLD_CAP_PEND && !buf_in_ready && !tog_edge && clr_s)
            |=> (st_reg.cap == SLD_CAP_PEND && $stable(st_reg.pend)))
        else $error("pending word lost under stall");

    // link chain and cascade stay cleared while the clear pin is low
    clr_link_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !i_clear_n |-> (link_word == `SLD_WORD_RST &&
                        o_cascade_out == `SLD_CAS_OFF))
        else $error("link side not held cleared");

    // clear empties the capture stage and flushes the buffer
    clr_flush_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !clr_s |=> (!buf_out_valid && st_reg.cap == SLD_CAP_IDLE &&
                    st_reg.pend == `SLD_WORD_RST))
        else $error("clear left a word in the path");

    // capture only reads a chain that has stopped moving
    capture_stable_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (tog_edge && clr_s) |-> $stable(link_word))
        else $error("chain moved during capture");

    // holding latch keeps the driver pins still
    pin_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!lat_s && clr_s && !dis_s) ##1 (clr_s && !dis_s) |=>
            $stable(o_driver_outputs))
        else $error("driver pins moved while holding");

    // a stalled buffer keeps its oldest word on offer
    out_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (buf_out_valid && !buf_out_ready && clr_s) |=>
            (buf_out_valid && $stable(buf_out_data)))
        else $error("stalled word left the buffer");

    // output register only changes through a drained word or a clear
    hold_source_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        ($changed(st_reg.hold) && $past(clr_s)) |->
            ($past(buf_out_valid) && $past(buf_out_ready)))
        else $error("output register changed without a word");

    // latch pin low keeps the register still three edges on
    latch_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!i_latch && i_clear_n) |-> ##3 $stable(st_reg.hold))
        else $error("latch pin low did not hold the register");

    // disable pin turns the drivers off three edges on
    dis_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_output_disable |-> ##3 o_driver_outputs == `SLD_OUT_OFF)
        else $error("disable pin did not turn drivers off");

    // enable and clear released show the register three edges on
    en_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!i_output_disable && i_clear_n) |-> ##3
            o_driver_outputs == $past(st_reg.hold))
        else $error("enabled pins differ from register");

    // clear pin turns the drivers off three edges on
    clr_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !i_clear_n |-> ##3 o_driver_outputs == `SLD_OUT_OFF)
        else $error("clear pin did not turn drivers off");

    // a shift with the latch open reaches the pins four edges on
    shift_to_pin_a: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (tog_edge && clr_s && !buf_out_valid &&
         st_reg.cap == SLD_CAP_IDLE) ##1
            (clr_s && lat_s && !dis_s)[*3] |=>
            o_driver_outputs == $past(link_word, 4))
        else $error("shifted word did not reach the pins");

endmodule // sld_top

// File: bench/sld_host.sv
`timescale 1ns/1ps

// host side of the shift link: clock idles low between frames
module sld_host
(
    input wire logic i_cascade_in,
    output logic o_shift_clk,
    output logic o_serial_data
);
    // half period of the shortest supported shift period
    localparam int HALF_NS = 50;

    logic cas_seen [0:15]; // cascade level just before each rise
    logic cas_rise [0:15]; // cascade level just after each rise

    // idle levels at time zero
    initial
    begin
        o_shift_clk = 1'b0;
        o_serial_data = 1'b0;
    end

    // shifts n bits msb first, so the first bit ends at output n-1, the top one for n of 16
    task automatic send(input logic [15:0] w, input int n);
        int k;
        for (k = n - 1; k >= 0; k--)
        begin
            o_serial_data = w[k];
            #(HALF_NS);
            cas_seen[n-1-k] = i_cascade_in;
            o_shift_clk = 1'b1;
            #1;
            cas_rise[n-1-k] = i_cascade_in;
            #(HALF_NS - 1);
            o_shift_clk = 1'b0;
        end
        o_serial_data = 1'b0; // pull-down level once released
        #(HALF_NS);
    endtask
endmodule // sld_host

// File: bench/sld_top_tb.sv
`timescale 1ns/1ps

module sld_top_tb
    import sld_pkg::*;
();
    logic mclk;
    logic rst_b;
    logic clear_n;
    logic latch;
    logic dis;
    logic sck;
    logic sdi;
    sld_word_t drv;
    logic cas;
    int fails;
    int num_checks;

    // core clock, 10 ns period
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    sld_top i_sld_top (
        .i_mclk(mclk),
        .i_rst_b(rst_b),
        .i_shift_clk(sck),
        .i_serial_data_in(sdi),
        .i_clear_n(clear_n),
        .i_latch(latch),
        .i_output_disable(dis),
        .o_driver_outputs(drv),
        .o_cascade_out(cas)
    );

    sld_host i_sld_host (
        .i_cascade_in(cas),
        .o_shift_clk(sck),
        .o_serial_data(sdi)
    );

    // counts one comparison and reports a mismatch
    task automatic chk(input sld_word_t got, input sld_word_t exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    // waits n core falling edges
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // prints counts and the verdict, then ends the run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // everything off straight after reset
    task automatic t_reset();
        chk(drv, 16'h0000);
        chk({15'h0000, cas}, 16'h0000);
    endtask

    // full word and a partial shift with the latch open
    task automatic t_shift();
        latch = 1'b1;
        wait_cyc(5);
        i_sld_host.send(16'ha5c3, 16);
        wait_cyc(15);
        chk(drv, 16'ha5c3);
        i_sld_host.send(16'h000b, 4);
        wait_cyc(15);
        chk(drv, 16'h5c3b);
    endtask

    // latch closed while three words pass, then reopened
    task automatic t_hold();
        latch = 1'b0;
        wait_cyc(5);
        i_sld_host.send(16'h1234, 16);
        i_sld_host.send(16'h8001, 16);
        i_sld_host.send(16'h0ff0, 16);
        wait_cyc(15);
        chk(drv, 16'h5c3b);
        latch = 1'b1;
        wait_cyc(15);
        chk(drv, 16'h0ff0);
    endtask

    // outputs forced off while disabled, word shown after
    task automatic t_disable();
        dis = 1'b1;
        wait_cyc(4);
        chk(drv, 16'h0000);
        i_sld_host.send(16'hf00f, 16);
        wait_cyc(15);
        chk(drv, 16'h0000);
        dis = 1'b0;
        wait_cyc(4);
        chk(drv, 16'hf00f);
    endtask

    // old word leaves on the cascade pin, steady across rising edges
    task automatic t_cascade();
        int k;
        i_sld_host.send(16'hc35a, 16);
        i_sld_host.send(16'h0000, 16);
        for (k = 0; k < 16; k++)
        begin
            chk({15'h0000, i_sld_host.cas_seen[k]},
                {15'h0000, 1'(16'hc35a >> (15 - k))});
            chk({15'h0000, i_sld_host.cas_rise[k]},
                {15'h0000, i_sld_host.cas_seen[k]});
        end
        wait_cyc(15);
        chk(drv, 16'h0000);
    endtask

    // clear empties the link side at once, the drivers three edges later, and blocks shifting
    task automatic t_clear();
        i_sld_host.send(16'hffff, 16);
        wait_cyc(15);
        chk(drv, 16'hffff);
        clear_n = 1'b0;
        wait_cyc(1);
        chk({15'h0000, cas}, 16'h0000);
        wait_cyc(5);
        chk(drv, 16'h0000);
        i_sld_host.send(16'hffff, 16);
        clear_n = 1'b1;
        wait_cyc(15);
        chk(drv, 16'h0000);
        chk({15'h0000, cas}, 16'h0000);
        i_sld_host.send(16'h0001, 1);
        wait_cyc(15);
        chk(drv, 16'h0001);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        fails = 0;
        num_checks = 0;
        rst_b = 1'b0;
        clear_n = 1'b1;
        latch = 1'b0;
        dis = 1'b0;
        // clear falls after time zero so the link side sees its edge
        @(negedge mclk);
        clear_n = 1'b0;
        repeat (11) @(negedge mclk);
        rst_b = 1'b1;
        clear_n = 1'b1;
        wait_cyc(5);
        t_reset();
        t_shift();
        t_hold();
        t_disable();
        t_cascade();
        t_clear();
        stop_test();
    end

    // cuts a hang short well beyond the expected run time
    initial
    begin
        #300000;
        fails++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end
endmodule // sld_top_tb
